// [common/arim_pkg.sv]
package arim_pkg;
  // Clock and sampling
  localparam int CLK_HZ          = 20_000_000;
  localparam int SAMPLE_TIME_US  = 1000;
  localparam int SAMPLE_CYCLES   = CLK_HZ / 1_000_000 * SAMPLE_TIME_US;

  // Register bus
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_TOL    = 5'h01;
  localparam logic [4:0] REG_FILT   = 5'h02;
  localparam logic [4:0] REG_FMIN   = 5'h03;
  localparam logic [4:0] REG_FMAX   = 5'h04;
  localparam logic [4:0] REG_PMIN   = 5'h05;
  localparam logic [4:0] REG_PMAX   = 5'h06;
  localparam logic [4:0] REG_SLIP   = 5'h07;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_REF    = 5'h09;
  localparam logic [4:0] REG_POINTS = 5'h10;

  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PCT_BIT  = 2;
  localparam int CTRL_SET_LSB  = 3;
  localparam int CTRL_MON_LSB  = 5;

  // Status fields
  localparam int ST_OVR_BIT  = 0;
  localparam int ST_WARN_BIT = 1;
  localparam int ST_DIG_BIT  = 2;
  localparam int ST_NEG_BIT  = 3;

  typedef enum logic [1:0] {
    MODE_VOLTAGE = 2'h1,
    MODE_CURRENT = 2'h2,
    MODE_DIGITAL = 2'h3
  } arim_mode_t;

  typedef enum logic [1:0] {
    MON_OFF   = 2'h0,
    MON_WARN  = 2'h1,
    MON_STOP  = 2'h2,
    MON_COAST = 2'h3
  } arim_mon_t;

  typedef enum logic {
    ZONE_POS = 1'b0,
    ZONE_NEG = 1'b1
  } arim_zone_t;

  // Values in hundredths of a percent or of a hertz
  localparam int FULL_SCALE      = 10000;
  localparam int ADC_W           = 12;
  localparam logic [11:0] ADC_MAX = 12'hfff;
  localparam int MON_THRESHOLD   = 1000;
  localparam int FREQ_LIMIT_MAX  = 59900;
  localparam int PCT_LIMIT_MAX   = 30000;
  localparam logic [15:0] OVR_ERR_CODE = 16'h1407;

  // Values after reset
  localparam logic [15:0] RST_X1   = 16'h00c8;
  localparam logic [15:0] RST_Y1   = 16'h0000;
  localparam logic [15:0] RST_X2   = 16'h2648;
  localparam logic [15:0] RST_Y2   = 16'h2710;
  localparam logic [15:0] RST_FMAX = 16'h1388;
  localparam logic [15:0] RST_FMIN_A = 16'h015e;
  localparam logic [15:0] RST_FMIN_B = 16'h0000;
  localparam logic [15:0] RST_PMIN = 16'h0000;
  localparam logic [15:0] RST_PMAX = 16'h2710;
  localparam logic [15:0] RST_TOL  = 16'h0000;
  localparam logic [15:0] RST_SLIP = 16'h0000;
  localparam logic [3:0]  RST_FILT = 4'h0;
  localparam int FILT_CODES = 15;
endpackage

// [rtl/arim_sync2.sv]
`timescale 1ns/1ps
module arim_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// [rtl/arim_lpf.sv]
`timescale 1ns/1ps
module arim_lpf (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        tick,
  input  wire logic [3:0]  code,
  input  wire logic [15:0] x_in,
  output logic      [15:0] y_out
);
  import arim_pkg::*;

  localparam int K_NUM = 65536 * SAMPLE_TIME_US / 1000;

  // Per-sample gain K_NUM / tau_ms
  function automatic logic [16:0] gain(input logic [3:0] c);
    case (c)
      4'h1:    gain = 17'(K_NUM / 2);
      4'h2:    gain = 17'(K_NUM / 4);
      4'h3:    gain = 17'(K_NUM / 8);
      4'h4:    gain = 17'(K_NUM / 16);
      4'h5:    gain = 17'(K_NUM / 32);
      4'h6:    gain = 17'(K_NUM / 64);
      4'h7:    gain = 17'(K_NUM / 128);
      4'h8:    gain = 17'(K_NUM / 256);
      4'h9:    gain = 17'(K_NUM / 512);
      4'ha:    gain = 17'(K_NUM / 1000);
      4'hb:    gain = 17'(K_NUM / 2000);
      4'hc:    gain = 17'(K_NUM / 3000);
      4'hd:    gain = 17'(K_NUM / 4000);
      4'he:    gain = 17'(K_NUM / 5000);
      default: gain = 17'h10000;
    endcase
  endfunction

  logic signed [33:0] acc;
  logic signed [33:0] diff;
  logic signed [51:0] step;

  always_comb
  begin
    diff = $signed({2'h0, x_in, 16'h0000}) - acc;
    step = (52'(diff) * $signed({35'h0, gain(code)})) >>> 16;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      acc <= '0;
    else if (tick)
    begin
      if (code == 4'h0)
        acc <= $signed({2'h0, x_in, 16'h0000});
      else
        acc <= acc + 34'(step);
    end
  end

  assign y_out = acc[31:16];
endmodule

// [rtl/arim_mapper.sv]
// Functional notes
// - Input runs as voltage (1), current (2) or digital (3).
// - Paths of the unselected modes present zero to their consumers.
// - After reset the input is in voltage mode as reference source.
// - Current mode flags overrange error F1407 when input exceeds range.
// - Two points per data set, four sets, defaults 2/0/98/100 percent.
// - X is percent of full scale; Y percent of maximum limit.
// - Output follows straight line through the two characteristic points.
// - Min and max limits act in both directions; Y relative to limits.
// - Frequency limits 0 to 599 Hz; max 50 Hz, min 3.5 or 0.
// - Effective upper frequency is maximum frequency plus compensated slip.
// - Percentage limits 0 to 300 percent, defaults 0 and 100.
// - Tolerance band widens the zero crossing of sign-changing lines.
// - Falling from positive, hold positive minimum until band is left.
// - Nonzero minimum turns the tolerance band into a hysteresis.
// - Filter time constant from fifteen codes, code 0 passes through.
// - Nonzero code low-pass filters the input value with that constant.
// - Direction reverses by direction input or by opposite-sign points.
// - Monitoring off, warning, warning and stop, or warning and coast.
`timescale 1ns/1ps
module arim_mapper #(
  parameter int  SAMPLE_DIV  = arim_pkg::SAMPLE_CYCLES,
  parameter bit  FAMILY_ZERO_FMIN = 1'b0
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  input  wire logic                          adc_valid,
  input  wire logic [arim_pkg::ADC_W-1:0]    adc_code,
  input  wire logic                          multifunction_digital_path,
  input  wire logic                          dir_reverse_pin,
  input  wire logic [arim_pkg::ADDR_W-1:0]   addr,
  input  wire logic [arim_pkg::DATA_W-1:0]   wr_data,
  input  wire logic                          wr_stb,
  input  wire logic                          rd_stb,
  output logic      [arim_pkg::DATA_W-1:0]   rd_data,
  output logic signed [19:0]                 ref_value,
  output logic                               ref_valid,
  output logic                               digital_level,
  output logic                               overrange_err,
  output logic      [15:0]                   err_code,
  output logic                               mon_warn,
  output logic                               mon_stop,
  output logic                               mon_coast
);
  import arim_pkg::*;

  localparam logic [15:0] RST_FMIN = FAMILY_ZERO_FMIN ? RST_FMIN_B
                                                      : RST_FMIN_A;

  function automatic logic [15:0] cap(input logic [15:0] v, input int lim);
    cap = (int'(v) > lim) ? 16'(lim) : v;
  endfunction

  function automatic logic signed [31:0] sx(input logic [15:0] v);
    sx = 32'($signed(v));
  endfunction

  function automatic logic signed [31:0] ux(input logic [15:0] v);
    ux = {16'h0000, v};
  endfunction

  // Control registers
  logic [1:0]  mode;
  logic        pct_sel;
  logic [1:0]  data_set;
  logic [1:0]  mon_mode;
  logic [15:0] tol;
  logic [3:0]  filt_code;
  logic [15:0] fmin;
  logic [15:0] fmax;
  logic [15:0] pmin;
  logic [15:0] pmax;
  logic [15:0] slip;
  logic [15:0] points [16];

  // Datapath
  logic [SAMPLE_DIV > 1 ? $clog2(SAMPLE_DIV)-1 : 0 : 0] div_cnt;
  logic        tick;
  logic [11:0] adc_hold;
  logic        dig_sync;
  logic        dir_sync;
  logic [15:0] x_raw;
  logic [15:0] x_filt;
  arim_zone_t  zone;
  arim_zone_t  next_zone;
  logic        analog_mode;
  logic signed [31:0] x;
  logic signed [31:0] x1;
  logic signed [31:0] y1;
  logic signed [31:0] x2;
  logic signed [31:0] y2;
  logic signed [31:0] y_line;
  logic signed [31:0] x_zero;
  logic signed [31:0] lim_min;
  logic signed [31:0] lim_max;
  logic signed [31:0] mag;
  logic signed [31:0] mag_clamped;
  logic signed [31:0] next_ref;
  logic        sign_change;
  logic        pos_high;
  logic        in_pos;
  logic        in_neg;
  logic        neg_out;
  logic [3:0]  pidx;

  arim_sync2 #(
    .W (2)
  ) u_sync (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in ({multifunction_digital_path, dir_reverse_pin}),
    .sync_out ({dig_sync, dir_sync})
  );

  // Sample period divider
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end
    else if (int'(div_cnt) >= SAMPLE_DIV - 1)
    begin
      div_cnt <= '0;
      tick    <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
      tick    <= 1'b0;
    end
  end

  // Register writes
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode      <= MODE_VOLTAGE;
      pct_sel   <= 1'b0;
      data_set  <= 2'h0;
      mon_mode  <= MON_OFF;
      tol       <= RST_TOL;
      filt_code <= RST_FILT;
      fmin      <= RST_FMIN;
      fmax      <= RST_FMAX;
      pmin      <= RST_PMIN;
      pmax      <= RST_PMAX;
      slip      <= RST_SLIP;
    end
    else if (wr_stb)
    begin
      case (addr)
        REG_CTRL:
        begin
          if (wr_data[CTRL_MODE_LSB +: 2] != 2'h0)
            mode <= wr_data[CTRL_MODE_LSB +: 2];
          pct_sel  <= wr_data[CTRL_PCT_BIT];
          data_set <= wr_data[CTRL_SET_LSB +: 2];
          mon_mode <= wr_data[CTRL_MON_LSB +: 2];
        end
        REG_TOL:  tol  <= cap(wr_data, FULL_SCALE);
        REG_FILT:
        begin
          if (int'(wr_data[3:0]) < FILT_CODES)
            filt_code <= wr_data[3:0];
        end
        REG_FMIN: fmin <= cap(wr_data, FREQ_LIMIT_MAX);
        REG_FMAX: fmax <= cap(wr_data, FREQ_LIMIT_MAX);
        REG_PMIN: pmin <= cap(wr_data, PCT_LIMIT_MAX);
        REG_PMAX: pmax <= cap(wr_data, PCT_LIMIT_MAX);
        REG_SLIP: slip <= wr_data;
        default:  ;
      endcase
    end
  end

  // Characteristic points, four data sets
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 16; i++)
      begin
        case (i % 4)
          0:       points[i] <= RST_X1;
          1:       points[i] <= RST_Y1;
          2:       points[i] <= RST_X2;
          default: points[i] <= RST_Y2;
        endcase
      end
    end
    else if (wr_stb && addr[4])
    begin
      if (addr[0])
      begin
        if ($signed(wr_data) > $signed(16'(FULL_SCALE)))
          points[addr[3:0]] <= 16'(FULL_SCALE);
        else if ($signed(wr_data) < -$signed(16'(FULL_SCALE)))
          points[addr[3:0]] <= 16'(-FULL_SCALE);
        else
          points[addr[3:0]] <= wr_data;
      end
      else
        points[addr[3:0]] <= cap(wr_data, FULL_SCALE);
    end
  end

  // Latest converter sample, held as the raw 12-bit code; scaled to hundredths of a percent below
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      adc_hold <= '0;
    else if (adc_valid)
      adc_hold <= adc_code;
  end

  assign analog_mode = (mode == MODE_VOLTAGE) || (mode == MODE_CURRENT);
  // Unselected analog path feeds zero
  assign x_raw = analog_mode ? 16'((32'(adc_hold) * FULL_SCALE) /
                                   int'(ADC_MAX)) : 16'h0000;

  arim_lpf u_lpf (
    .mclk  (mclk),
    .rst_b (rst_b),
    .tick  (tick),
    .code  (filt_code),
    .x_in  (x_raw),
    .y_out (x_filt)
  );

  // Mapping through the characteristic
  always_comb
  begin
    pidx    = {data_set, 2'h0};
    x       = ux(x_filt);
    x1      = ux(points[pidx]);
    y1      = sx(points[pidx + 4'h1]);
    x2      = ux(points[pidx + 4'h2]);
    y2      = sx(points[pidx + 4'h3]);
    if (x2 == x1)
      y_line = y1;
    else
      y_line = ((y2 - y1) * (x - x1)) / (x2 - x1) + y1;
    if (y_line > FULL_SCALE)
      y_line = FULL_SCALE;
    else if (y_line < -FULL_SCALE)
      y_line = -FULL_SCALE;
    sign_change = (y1 < 0 && y2 > 0) || (y1 > 0 && y2 < 0);
    pos_high    = (y2 > y1);
    if (sign_change)
      x_zero = x1 - (y1 * (x2 - x1)) / (y2 - y1);
    else
      x_zero = '0;
    // Band around the zero crossing
    if (pos_high)
    begin
      in_pos = x > x_zero + ux(tol);
      in_neg = x < x_zero - ux(tol);
    end
    else
    begin
      in_pos = x < x_zero - ux(tol);
      in_neg = x > x_zero + ux(tol);
    end
    lim_min = pct_sel ? ux(pmin) : ux(fmin);
    lim_max = pct_sel ? ux(pmax) : ux(fmax) + ux(slip);
    if (lim_max < lim_min)
      lim_max = lim_min;
    mag = ((y_line < 0 ? -y_line : y_line) * lim_max) / FULL_SCALE;
    if (mag < lim_min)
      mag_clamped = lim_min;
    else if (mag > lim_max)
      mag_clamped = lim_max;
    else
      mag_clamped = mag;
  end

  always_comb
  begin
    next_zone = zone;
    if (sign_change)
    begin
      case (zone)
        ZONE_POS: if (in_neg) next_zone = ZONE_NEG;
        ZONE_NEG: if (in_pos) next_zone = ZONE_POS;
        default:  next_zone = ZONE_POS;
      endcase
    end
    else
      next_zone = (y_line < 0) ? ZONE_NEG : ZONE_POS;
  end

  always_comb
  begin
    neg_out  = 1'b0;
    next_ref = '0;
    if (!analog_mode)
      next_ref = '0;
    else if (sign_change && !in_pos && !in_neg)
    begin
      // Inside the band: zero, or held minimum as a hysteresis
      neg_out  = (next_zone == ZONE_NEG);
      next_ref = lim_min;
    end
    else
    begin
      neg_out  = (y_line < 0);
      next_ref = (y_line == 0 && lim_min == 0) ? 32'sd0 : mag_clamped;
    end
    if (neg_out ^ dir_sync)
      next_ref = -next_ref;
  end

  // Reference output, once per sample period
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_value <= '0;
      ref_valid <= 1'b0;
      zone      <= ZONE_POS;
    end
    else
    begin
      ref_valid <= tick;
      if (tick)
      begin
        ref_value <= 20'(next_ref);
        zone      <= analog_mode ? next_zone : ZONE_POS;
      end
    end
  end

  // Slow digital path, zero outside digital mode
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      digital_level <= 1'b0;
    else if (tick)
      digital_level <= (mode == MODE_DIGITAL) && dig_sync;
  end

  // Current overrange, sticky; set wins over a clear
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      overrange_err <= 1'b0;
    else if (mode == MODE_CURRENT && adc_valid && adc_code == ADC_MAX)
      overrange_err <= 1'b1;
    else if (wr_stb && addr == REG_STATUS && wr_data[ST_OVR_BIT])
      overrange_err <= 1'b0;
  end

  assign err_code = overrange_err ? OVR_ERR_CODE : 16'h0000;

  // Low signal monitoring below one tenth of full scale
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mon_warn  <= 1'b0;
      mon_stop  <= 1'b0;
      mon_coast <= 1'b0;
    end
    else if (tick)
    begin
      mon_warn  <= analog_mode && mon_mode != MON_OFF &&
                   int'(x_raw) < MON_THRESHOLD;
      mon_stop  <= analog_mode && mon_mode == MON_STOP &&
                   int'(x_raw) < MON_THRESHOLD;
      mon_coast <= analog_mode && mon_mode == MON_COAST &&
                   int'(x_raw) < MON_THRESHOLD;
    end
  end

  // Register reads, unmapped reads return zero
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data <= '0;
    else if (rd_stb)
    begin
      if (addr[4])
        rd_data <= points[addr[3:0]];
      else
      begin
        case (addr)
          REG_CTRL:   rd_data <= {9'h000, mon_mode, data_set, pct_sel, mode};
          REG_TOL:    rd_data <= tol;
          REG_FILT:   rd_data <= {12'h000, filt_code};
          REG_FMIN:   rd_data <= fmin;
          REG_FMAX:   rd_data <= fmax;
          REG_PMIN:   rd_data <= pmin;
          REG_PMAX:   rd_data <= pmax;
          REG_SLIP:   rd_data <= slip;
          REG_STATUS: rd_data <= {12'h000, zone == ZONE_NEG, digital_level,
                                  mon_warn, overrange_err};
          REG_REF:    rd_data <= ref_value[15:0];
          default:    rd_data <= '0;
        endcase
      end
    end
  end
endmodule

// [tb/arim_mapper_asserts.sv]
`timescale 1ns/1ps
module arim_mapper_asserts
  import arim_pkg::*;
#(
  parameter int SAMPLE_DIV = 20
) (
  input wire logic               mclk,
  input wire logic               rst_b,
  input wire logic               adc_valid,
  input wire logic [11:0]        adc_code,
  input wire logic [4:0]         addr,
  input wire logic [15:0]        wr_data,
  input wire logic               wr_stb,
  input wire logic signed [19:0] ref_value,
  input wire logic               ref_valid,
  input wire logic               digital_level,
  input wire logic               overrange_err,
  input wire logic [15:0]        err_code,
  input wire logic               mon_warn,
  input wire logic               mon_stop,
  input wire logic               mon_coast
);
  logic [31:0] gap;
  logic        seen;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Cycles since the last reference update
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      gap  <= '0;
      seen <= 1'b0;
    end
    else if (ref_valid)
    begin
      gap  <= '0;
      seen <= 1'b1;
    end
    else
      gap <= gap + 32'h1;

  pulse_once_a: assert property (ref_valid |=> !ref_valid)
    else $error("ref_valid longer than one cycle");
  tick_space_a: assert property (
    ref_valid && seen |-> gap == SAMPLE_DIV - 1)
    else $error("reference update spacing wrong");
  ref_hold_a: assert property (!ref_valid |-> $stable(ref_value))
    else $error("ref_value moved without ref_valid");
  err_code_a: assert property (
    err_code == (overrange_err ? OVR_ERR_CODE : 16'h0000))
    else $error("err_code does not match overrange");
  ovr_cause_a: assert property ($rose(overrange_err) |->
    $past(adc_valid) && $past(adc_code) == 12'hfff)
    else $error("overrange raised without full scale sample");
  ovr_clear_a: assert property (wr_stb && addr == REG_STATUS
    && wr_data[0] && !(adc_valid && adc_code == 12'hfff) |=> !overrange_err)
    else $error("overrange not cleared");
  ovr_stick_a: assert property (overrange_err
    && !(wr_stb && addr == REG_STATUS) |=> overrange_err)
    else $error("overrange dropped by itself");
  dig_zero_a: assert property (
    digital_level && ref_valid |-> ref_value == 0)
    else $error("reference nonzero in digital mode");
  mon_order_a: assert property (mon_stop || mon_coast |->
    mon_warn && !(mon_stop && mon_coast))
    else $error("monitor outputs inconsistent");

  cover property (ref_valid);
  cover property ($rose(overrange_err));
  cover property (mon_coast);
endmodule

bind arim_mapper arim_mapper_asserts #(
  .SAMPLE_DIV (SAMPLE_DIV)
) arim_mapper_asserts_i (
  .mclk(mclk), .rst_b(rst_b), .adc_valid(adc_valid), .adc_code(adc_code),
  .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .ref_value(ref_value),
  .ref_valid(ref_valid), .digital_level(digital_level),
  .overrange_err(overrange_err), .err_code(err_code), .mon_warn(mon_warn),
  .mon_stop(mon_stop), .mon_coast(mon_coast));

// [tb/arim_fe_model.sv]
`timescale 1ns/1ps
module arim_fe_model #(
  parameter int PERIOD = 7
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [11:0] level,
  input  wire logic        dig_level,
  output logic             adc_valid,
  output logic      [11:0] adc_code,
  output logic             dig_pin
);
  int cnt;

  // Code is only meaningful beside the strobe; otherwise it is scrambled
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      cnt       <= 0;
      adc_valid <= 1'b0;
      adc_code  <= 12'h0;
    end
    else
    begin
      cnt       <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      adc_valid <= (cnt == PERIOD - 1);
      adc_code  <= (cnt == PERIOD - 1) ? level : ~level;
    end

  // Digital level changes only slowly, many samples apart
  assign dig_pin = dig_level;
endmodule

// [tb/arim_mapper_tb.sv]
`timescale 1ns/1ps
module arim_mapper_tb;
  import arim_pkg::*;
  logic               mclk = 1'b0;
  logic               rst_b = 1'b0;
  logic [4:0]         addr = 5'h0;
  logic [15:0]        wr_data = 16'h0;
  logic               wr_stb = 1'b0;
  logic               rd_stb = 1'b0;
  logic               dir_pin = 1'b0;
  logic [11:0]        level = 12'h0;
  logic               dig_level = 1'b0;
  logic               adc_valid;
  logic [11:0]        adc_code;
  logic               dig_pin;
  logic [15:0]        rd_data;
  logic signed [19:0] ref_value;
  logic               ref_valid;
  logic               digital_level;
  logic               overrange_err;
  logic [15:0]        err_code;
  logic               mon_warn;
  logic               mon_stop;
  logic               mon_coast;
  int                 mismatches = 0;
  int                 compares = 0;

  always #25 mclk = ~mclk;

  arim_fe_model arim_fe_model_i (.mclk(mclk), .rst_b(rst_b), .level(level),
    .dig_level(dig_level), .adc_valid(adc_valid), .adc_code(adc_code),
    .dig_pin(dig_pin));

  arim_mapper #(.SAMPLE_DIV(20)) arim_mapper_i (.mclk(mclk), .rst_b(rst_b),
    .adc_valid(adc_valid), .adc_code(adc_code),
    .multifunction_digital_path(dig_pin), .dir_reverse_pin(dir_pin),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .ref_value(ref_value), .ref_valid(ref_valid),
    .digital_level(digital_level), .overrange_err(overrange_err),
    .err_code(err_code), .mon_warn(mon_warn), .mon_stop(mon_stop),
    .mon_coast(mon_coast));

  task automatic close_out();
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("FAIL %0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    chk(20'(rd_data), 20'(e));
  endtask

  // Lets three reference updates pass so the new level is processed
  task automatic settle();
    int n;
    int t;
    n = 0;
    t = 0;
    while (n < 3)
    begin
      @(posedge mclk);
      #1;
      t++;
      if (ref_valid === 1'b1) n++;
      if (t > 400)
      begin
        mismatches++;
        close_out();
      end
    end
  endtask

  task automatic pts(input logic [15:0] y1, x2, y2);
    wr(REG_POINTS, 16'h0);
    wr(REG_POINTS + 5'h1, y1);
    wr(REG_POINTS + 5'h2, x2);
    wr(REG_POINTS + 5'h3, y2);
  endtask

  function automatic int mapv(int adc, x1, y1, x2, y2, lo, hi);
    int x;
    int y;
    int m;
    x = adc * 10000 / 4095;
    y = (y2 - y1) * (x - x1) / (x2 - x1) + y1;
    if (y > 10000) y = 10000;
    if (y < -10000) y = -10000;
    m = (y < 0 ? -y : y) * hi / 10000;
    if (m < lo) m = lo;
    if (m > hi) m = hi;
    return y < 0 ? -m : m;
  endfunction

  task automatic t_defaults();
    rchk(REG_CTRL, 16'h0001);
    rchk(REG_FMAX, 16'h1388);
    rchk(REG_FMIN, 16'h015e);
    rchk(REG_PMIN, 16'h0000);
    rchk(REG_PMAX, 16'h2710);
    for (int s = 0; s < 4; s++)
    begin
      rchk(REG_POINTS + 5'(s * 4), 16'h00c8);
      rchk(REG_POINTS + 5'(s * 4 + 1), 16'h0000);
      rchk(REG_POINTS + 5'(s * 4 + 2), 16'h2648);
      rchk(REG_POINTS + 5'(s * 4 + 3), 16'h2710);
    end
    rchk(5'h0a, 16'h0000);
    level <= 12'hfff;
    settle();
    chk(ref_value, 20'(mapv(4095, 200, 0, 9800, 10000, 350, 5000)));
    chk(20'(digital_level), 20'h0);
  endtask

  task automatic t_scale();
    wr(REG_FMAX, 16'd4000);
    wr(REG_SLIP, 16'd200);
    settle();
    chk(ref_value, 20'd4200);
    wr(REG_FMAX, 16'hffff);
    rchk(REG_FMAX, 16'he9fc);
    wr(REG_PMAX, 16'h9c40);
    rchk(REG_PMAX, 16'h7530);
    pts(16'h0, 16'h2710, 16'h2710);
    wr(REG_FMAX, 16'd5000);
    wr(REG_SLIP, 16'h0);
    level <= 12'd41;
    settle();
    chk(ref_value, 20'(mapv(41, 0, 0, 10000, 10000, 350, 5000)));
    wr(REG_CTRL, 16'h0005);
    wr(REG_PMAX, 16'd20000);
    level <= 12'd2048;
    settle();
    chk(ref_value, 20'(mapv(2048, 0, 0, 10000, 10000, 0, 20000)));
  endtask

  task automatic t_reverse();
    wr(REG_PMAX, 16'h2710);
    pts(16'h2710, 16'h2710, 16'h0);
    level <= 12'd1229;
    settle();
    chk(ref_value, 20'(mapv(1229, 0, 10000, 10000, 0, 0, 10000)));
    @(posedge mclk);
    dir_pin <= 1'b1;
    settle();
    chk(ref_value, 20'(-mapv(1229, 0, 10000, 10000, 0, 0, 10000)));
    @(posedge mclk);
    dir_pin <= 1'b0;
  endtask

  // Falling through the band keeps the positive minimum, rising keeps negative
  task automatic t_band();
    int lv[4] = '{3686, 2048, 1229, 2048};
    int e;
    pts(16'hd8f0, 16'h2710, 16'h2710);
    wr(REG_PMIN, 16'd1000);
    wr(REG_TOL, 16'd1000);
    for (int i = 0; i < 4; i++)
    begin
      level <= 12'(lv[i]);
      settle();
      e = mapv(lv[i], 0, -10000, 10000, 10000, 1000, 10000);
      if (i == 1) e = 1000;
      if (i == 3) e = -1000;
      chk(ref_value, 20'(e));
      if (i == 3) rchk(REG_STATUS, 16'h0008);
    end
    wr(REG_PMIN, 16'h0);
    wr(REG_TOL, 16'h0);
  endtask

  task automatic t_filter();
    pts(16'h0, 16'h2710, 16'h2710);
    level <= 12'h0;
    settle();
    chk(ref_value, 20'h0);
    for (int c = 0; c < 15; c++)
    begin
      wr(REG_FILT, 16'(c));
      rchk(REG_FILT, 16'(c));
    end
    wr(REG_FILT, 16'd15);
    rchk(REG_FILT, 16'd14);
    level <= 12'hfff;
    settle();
    chk(20'(ref_value > 0 && ref_value < 10000), 20'h1);
    wr(REG_FILT, 16'h0);
    settle();
    chk(ref_value, 20'd10000);
    wr(REG_POINTS + 5'h7, 16'h1388);
    wr(REG_CTRL, 16'h000d);
    rchk(REG_CTRL, 16'h000d);
    settle();
    chk(ref_value, 20'(mapv(4095, 200, 0, 9800, 5000, 0, 10000)));
  endtask

  task automatic t_monitor();
    wr(REG_POINTS, 16'd1000);
    level <= 12'd41;
    for (int m = 0; m < 4; m++)
    begin
      wr(REG_CTRL, 16'h0005 | 16'(m << 5));
      settle();
      chk(20'({mon_warn, mon_stop, mon_coast}),
          20'({m != 0, m == 2, m == 3}));
    end
    level <= 12'hfff;
    settle();
    chk(20'({mon_warn, mon_stop, mon_coast}), 20'h0);
  endtask

  task automatic t_modes();
    dig_level <= 1'b1;
    wr(REG_CTRL, 16'h0007);
    settle();
    chk(20'(digital_level), 20'h1);
    chk(ref_value, 20'h0);
    wr(REG_CTRL, 16'h0000);
    rchk(REG_CTRL, 16'h0003);
    wr(REG_CTRL, 16'h0006);
    settle();
    chk(20'(digital_level), 20'h0);
    chk(20'({overrange_err, err_code}), 20'h11407);
    wr(REG_STATUS, 16'h0001);
    settle();
    chk(20'(overrange_err), 20'h1);
    level <= 12'd100;
    settle();
    wr(REG_STATUS, 16'h0001);
    #1;
    chk(20'({overrange_err, err_code}), 20'h0);
    wr(REG_CTRL, 16'h0005);
    level <= 12'hfff;
    settle();
    chk(20'(overrange_err), 20'h0);
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_defaults();
    t_scale();
    t_reverse();
    t_band();
    t_filter();
    t_monitor();
    t_modes();
    close_out();
  end
endmodule
